// >>> rtl/flame_monitor_supervisor.sv
// Supervisor: status bytes, error tagging, samples, lockout and LEDs
//
// Functional notes
// - Each channel status byte holds span, unused, flame, harmonic, range, switch difference, frequency and intensity flags from the top bit down.
// - The error byte carries the source channel in bit 7 (1 = channel one) and the 7-bit error code below it.
// - Minimum, maximum and RMS of the last complete 128-sample record are reported.
// - Samples are packed two per word from word 0x815 to 0x854, even sample high, odd sample low.
// - A detected fault locks out, drops both relays, lights the error LED and blinks the power LED.
// - During lockout the power LED blinks a count equal to the fault cause code.
// - A reset key press acknowledges the fault, darkens all LEDs and restarts monitoring.
// - After a power cycle or reset key press the relays drop and monitoring restarts from the start.
// - A channel setting mismatch lights the switch error LED and after more than 8 s causes a shutdown.
// - A flicker frequency constant for 10 s forces flame off, blinks the frequency LED and sets current to CURRENT_72MA on 4-20 span, else CURRENT_4MA.
// - Harmonic detection is off whenever the frequency threshold is zero.
`timescale 1ns/10ps
module flame_monitor_supervisor
  import flame_sup_pkg::*;
#(
  parameter longint MISMATCH_LIMIT = MISMATCH_CYC,
  parameter longint HARMONIC_LIMIT = HARMONIC_CYC,
  parameter longint BLINK_HALF     = BLINK_HALF_CYC
)(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  input  wire logic        RESET_KEY,
  input  chan_in_s         CH_ONE,
  input  chan_in_s         CH_TWO,
  input  wire logic        SAMPLE_VALID,
  input  wire logic [7:0]  SAMPLE,
  input  wire logic        RECORD_START,
  input  wire logic        RD_EN,
  input  wire logic [11:0] RD_ADDR,
  output logic      [15:0] RD_DATA,
  output logic             RD_VALID,
  output logic             FLAME_RELAY,
  output logic             READY_RELAY,
  output logic             LED_ERROR,
  output logic             LED_POWER,
  output logic             LED_SWITCH,
  output logic             LED_FREQ,
  output logic       [7:0] CURRENT_OUT
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  sup_state_e    state_reg;
  logic [7:0]    cause_reg;
  logic [6:0]    err_code_reg;
  logic          err_src_reg;
  logic [31:0]   mismatch_cnt_reg;
  logic [31:0]   harm_cnt_reg;
  logic [7:0]    last_freq_reg;
  logic          harm_reg;
  logic [7:0]    samples_reg [NUM_SAMPLES];
  logic [6:0]    wr_idx_reg;
  logic [31:0]   blink_cnt_reg;
  logic [7:0]    pulse_cnt_reg;
  logic          blink_phase_reg;
  logic [2:0]    gap_cnt_reg;
  logic          freq_blink_reg;
  sample_stats_s stats;
  logic          mismatch;
  logic          mismatch_trip;
  logic          harm_enable;
  logic          fault_any;
  logic          blink_tick;

  assign mismatch    = CH_ONE.setting_mismatch | CH_TWO.setting_mismatch;
  assign mismatch_trip = mismatch && mismatch_cnt_reg >= 32'(MISMATCH_LIMIT);
  assign harm_enable = CH_ONE.freq_threshold != 8'h00;
  assign fault_any   = CH_ONE.fault | CH_TWO.fault | mismatch_trip;
  assign blink_tick  = blink_cnt_reg >= 32'(BLINK_HALF - 1);

  function automatic logic [7:0] status_byte(input chan_in_s c,
                                             input logic h);
    logic [7:0] s;
    s = 8'h00;
    s[STAT_SPAN]   = c.span_4_20;
    s[STAT_FLAME]  = c.flame & ~h;
    s[STAT_HARM]   = h;
    s[STAT_RANGE]  = c.range_b;
    s[STAT_SWDIFF] = c.setting_mismatch;
    s[STAT_FREQ]   = c.flicker_on;
    s[STAT_INTENS] = c.flame;
    return s;
  endfunction : status_byte

  // ****************************************************************
  // Statistics
  // ****************************************************************
  sample_stats u_stats (
    .CLK          (CLK),
    .RST_N        (RST_N),
    .CE           (CE),
    .SAMPLE_VALID (SAMPLE_VALID),
    .SAMPLE       (SAMPLE),
    .RECORD_START (RECORD_START),
    .STATS        (stats)
  );

  // ****************************************************************
  // Sample buffer
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_idx_reg <= 7'h00;
    end else if (CE) begin
      if (RECORD_START) begin
        wr_idx_reg <= 7'h00;
      end else if (SAMPLE_VALID) begin
        samples_reg[wr_idx_reg] <= SAMPLE;
        wr_idx_reg <= wr_idx_reg + 7'h01;
      end
    end
  end

  // ****************************************************************
  // Supervisor state
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_reg    <= ST_RUN;
      cause_reg    <= 8'h00;
      err_code_reg <= 7'h00;
      err_src_reg  <= 1'b0;
    end else if (CE) begin
      case (state_reg)
        ST_RUN: begin
          if (fault_any) begin
            state_reg <= ST_LOCKED;
            err_src_reg <= CH_ONE.fault;
            if (CH_ONE.fault) begin
              cause_reg    <= CH_ONE.fault_cause;
              err_code_reg <= CH_ONE.error_code;
            end else if (CH_TWO.fault) begin
              cause_reg    <= CH_TWO.fault_cause;
              err_code_reg <= CH_TWO.error_code;
            end else begin
              cause_reg    <= CAUSE_SWITCH;
              err_code_reg <= 7'h00;
            end
          end
        end
        ST_LOCKED: begin
          if (RESET_KEY) state_reg <= ST_RUN;
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  // ****************************************************************
  // Switch mismatch timer
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mismatch_cnt_reg <= 32'h0;
    end else if (CE) begin
      if (!mismatch || state_reg != ST_RUN)
        mismatch_cnt_reg <= 32'h0;
      else if (!mismatch_trip)
        mismatch_cnt_reg <= mismatch_cnt_reg + 32'h1;
    end
  end

  // ****************************************************************
  // Harmonic detection
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      harm_cnt_reg  <= 32'h0;
      last_freq_reg <= 8'h00;
      harm_reg      <= 1'b0;
    end else if (CE) begin
      last_freq_reg <= CH_ONE.freq_value;
      if (!harm_enable || state_reg != ST_RUN || RESET_KEY) begin
        harm_cnt_reg <= 32'h0;
        harm_reg     <= 1'b0;
      end else if (CH_ONE.freq_value != last_freq_reg) begin
        harm_cnt_reg <= 32'h0;
        harm_reg     <= 1'b0;
      end else if (harm_cnt_reg >= 32'(HARMONIC_LIMIT - 1)) begin
        harm_reg <= 1'b1;
      end else begin
        harm_cnt_reg <= harm_cnt_reg + 32'h1;
      end
    end
  end

  // ****************************************************************
  // Blink timing
  // ****************************************************************
  // Pulse train: cause pulses then a dark pause of five half periods
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      blink_cnt_reg   <= 32'h0;
      pulse_cnt_reg   <= 8'h00;
      blink_phase_reg <= 1'b0;
      gap_cnt_reg     <= 3'h0;
      freq_blink_reg  <= 1'b0;
    end else if (CE) begin
      if (blink_tick) begin
        blink_cnt_reg  <= 32'h0;
        freq_blink_reg <= ~freq_blink_reg;
        if (state_reg != ST_LOCKED) begin
          pulse_cnt_reg   <= 8'h00;
          blink_phase_reg <= 1'b0;
          gap_cnt_reg     <= 3'h0;
        end else if (gap_cnt_reg != 3'h0) begin
          gap_cnt_reg <= gap_cnt_reg - 3'h1;
        end else if (!blink_phase_reg) begin
          blink_phase_reg <= 1'b1;
        end else begin
          blink_phase_reg <= 1'b0;
          if (pulse_cnt_reg + 8'h01 >= cause_reg) begin
            pulse_cnt_reg <= 8'h00;
            gap_cnt_reg   <= 3'h4;
          end else begin
            pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
          end
        end
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 32'h1;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      FLAME_RELAY <= 1'b0;
      READY_RELAY <= 1'b0;
      LED_ERROR   <= 1'b0;
      LED_POWER   <= 1'b0;
      LED_SWITCH  <= 1'b0;
      LED_FREQ    <= 1'b0;
      CURRENT_OUT <= 8'h00;
    end else if (CE) begin
      if (RESET_KEY) begin
        FLAME_RELAY <= 1'b0;
        READY_RELAY <= 1'b0;
        LED_ERROR   <= 1'b0;
        LED_POWER   <= 1'b0;
        LED_SWITCH  <= 1'b0;
        LED_FREQ    <= 1'b0;
      end else if (state_reg == ST_LOCKED) begin
        FLAME_RELAY <= 1'b0;
        READY_RELAY <= 1'b0;
        LED_ERROR   <= 1'b1;
        LED_POWER   <= blink_phase_reg;
      end else begin
        FLAME_RELAY <= CH_ONE.flame & CH_TWO.flame & ~harm_reg;
        READY_RELAY <= 1'b1;
        LED_ERROR   <= 1'b0;
        LED_POWER   <= 1'b1;
        LED_SWITCH  <= mismatch;
        LED_FREQ    <= harm_reg ? freq_blink_reg : CH_ONE.flicker_on;
        if (harm_reg)
          CURRENT_OUT <= CH_ONE.span_4_20 ? CURRENT_72MA : CURRENT_4MA;
        else
          CURRENT_OUT <= CH_ONE.flame ? 8'hff : 8'h00;
      end
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RD_DATA  <= 16'h0000;
      RD_VALID <= 1'b0;
    end else if (CE) begin
      RD_VALID <= RD_EN;
      if (RD_EN) begin
        if (RD_ADDR == ADDR_STATUS)
          RD_DATA <= {status_byte(CH_ONE, harm_reg),
                      status_byte(CH_TWO, harm_reg)};
        else if (RD_ADDR == ADDR_TAG_ERROR)
          RD_DATA <= {8'h00, err_src_reg, err_code_reg};
        else if (RD_ADDR == ADDR_MINMAX)
          RD_DATA <= {stats.min_v, stats.max_v};
        else if (RD_ADDR == ADDR_RMS)
          RD_DATA <= {stats.rms_v, 8'h00};
        else if (RD_ADDR >= ADDR_SAMPLES && RD_ADDR <= ADDR_SAMP_LAST)
          RD_DATA <= {samples_reg[{6'(RD_ADDR - ADDR_SAMPLES), 1'b0}],
                      samples_reg[{6'(RD_ADDR - ADDR_SAMPLES), 1'b1}]};
        else
          RD_DATA <= 16'h0000;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_lock_relays: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && state_reg == ST_LOCKED && !RESET_KEY
      |=> !FLAME_RELAY && !READY_RELAY && LED_ERROR)
    else $error("relays not dropped in lockout");

  chk_key_dark: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && RESET_KEY |=> !LED_ERROR && !LED_POWER && !LED_FREQ)
    else $error("LEDs lit after reset key");

  chk_harm_off: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && !harm_enable |=> !harm_reg)
    else $error("harmonic set while disabled");

  chk_harm_flame: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && harm_reg && state_reg == ST_RUN && !RESET_KEY |=> !FLAME_RELAY)
    else $error("flame relay on with harmonic");

  chk_mismatch_led: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && mismatch && state_reg == ST_RUN && !RESET_KEY |=> LED_SWITCH)
    else $error("switch LED dark on mismatch");

  chk_trip_lock: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && mismatch_trip && state_reg == ST_RUN |=> state_reg == ST_LOCKED)
    else $error("mismatch did not lock out");

  chk_lock_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    state_reg == ST_LOCKED && !RESET_KEY |=> state_reg == ST_LOCKED)
    else $error("lockout left without reset");

  chk_err_tag: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && state_reg == ST_RUN && CH_ONE.fault
      |=> err_src_reg && err_code_reg == $past(CH_ONE.error_code))
    else $error("error byte mistagged");

endmodule : flame_monitor_supervisor

// >>> rtl/flame_sup_pkg.sv
// Package: constants and carriers for the flame monitor supervisor
package flame_sup_pkg;

  // ****************************************************************
  // Register map (word addresses)
  // ****************************************************************
  localparam logic [11:0] ADDR_STATUS    = 12'h80e;
  localparam logic [11:0] ADDR_ERROR_CH  = 12'h810;
  localparam logic [11:0] ADDR_MINMAX    = 12'h813;
  localparam logic [11:0] ADDR_RMS       = 12'h814;
  localparam logic [11:0] ADDR_SAMPLES   = 12'h815;
  localparam logic [11:0] ADDR_SAMP_LAST = 12'h854;
  localparam logic [11:0] ADDR_TAG_ERROR = 12'h8f0;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int STAT_SPAN   = 7;
  localparam int STAT_FLAME  = 5;
  localparam int STAT_HARM   = 4;
  localparam int STAT_RANGE  = 3;
  localparam int STAT_SWDIFF = 2;
  localparam int STAT_FREQ   = 1;
  localparam int STAT_INTENS = 0;
  localparam int ERR_SRC_BIT = 7;

  localparam int NUM_SAMPLES = 128;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint CLK_HZ         = 100000000;
  localparam longint MISMATCH_S     = 8;
  localparam longint HARMONIC_S     = 10;
  localparam longint MISMATCH_CYC   = MISMATCH_S * CLK_HZ;
  localparam longint HARMONIC_CYC   = HARMONIC_S * CLK_HZ;
  localparam longint BLINK_HALF_MS  = 250;
  localparam longint BLINK_HALF_CYC = BLINK_HALF_MS * CLK_HZ / 1000;
  localparam logic [7:0] CAUSE_SWITCH = 8'h02;
  localparam logic [7:0] CURRENT_4MA  = 8'h00;
  localparam logic [7:0] CURRENT_72MA = 8'h20;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_LOCKED
  } sup_state_e;

  typedef struct packed {
    logic       span_4_20;
    logic       flame;
    logic       flicker_on;
    logic       range_b;
    logic       setting_mismatch;
    logic [7:0] freq_threshold;
    logic [7:0] freq_value;
    logic       fault;
    logic [7:0] fault_cause;
    logic [6:0] error_code;
  } chan_in_s;

  typedef struct packed {
    logic [7:0] min_v;
    logic [7:0] max_v;
    logic [7:0] rms_v;
  } sample_stats_s;

endpackage : flame_sup_pkg

// >>> rtl/sample_stats.sv
// Sample statistics over a record of raw sensor samples
`timescale 1ns/10ps
module sample_stats
  import flame_sup_pkg::*;
(
  input  wire logic          CLK,
  input  wire logic          RST_N,
  input  wire logic          CE,
  input  wire logic          SAMPLE_VALID,
  input  wire logic [7:0]    SAMPLE,
  input  wire logic          RECORD_START,
  output sample_stats_s      STATS
);

  logic [7:0]  min_reg;
  logic [7:0]  max_reg;
  logic [22:0] sq_sum_reg;
  logic [7:0]  cnt_reg;

  // Both factors widened first so the product keeps all 16 bits
  function automatic logic [15:0] square(input logic [7:0] v);
    return 16'(v) * 16'(v);
  endfunction : square

  function automatic logic [7:0] isqrt(input logic [15:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      r[b] = 1'b1;
      if (square(r) > v) begin
        r[b] = 1'b0;
      end
    end
    return r;
  endfunction : isqrt

  // Stats freeze at record end so reads see the last complete record's figures
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      min_reg    <= 8'hff;
      max_reg    <= 8'h00;
      sq_sum_reg <= 23'h0;
      cnt_reg    <= 8'h00;
      STATS      <= '0;
    end else if (CE) begin
      if (RECORD_START) begin
        min_reg    <= 8'hff;
        max_reg    <= 8'h00;
        sq_sum_reg <= 23'h0;
        cnt_reg    <= 8'h00;
      end else if (SAMPLE_VALID && cnt_reg < 8'(NUM_SAMPLES)) begin
        if (SAMPLE < min_reg) min_reg <= SAMPLE;
        if (SAMPLE > max_reg) max_reg <= SAMPLE;
        sq_sum_reg <= sq_sum_reg + 23'(square(SAMPLE));
        cnt_reg    <= cnt_reg + 8'h01;
        if (cnt_reg == 8'(NUM_SAMPLES - 1)) begin
          STATS.min_v <= (SAMPLE < min_reg) ? SAMPLE : min_reg;
          STATS.max_v <= (SAMPLE > max_reg) ? SAMPLE : max_reg;
          STATS.rms_v <= isqrt(16'((sq_sum_reg
                           + 23'(square(SAMPLE))) >> 7));
        end
      end
    end
  end

endmodule : sample_stats

// >>> sim/fieldbus_master.sv
// Fieldbus master model that issues register reads to the supervisor
`timescale 1ns/10ps
module fieldbus_master
  import flame_sup_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RD_VALID,
  input  wire logic [15:0] RD_DATA,
  output logic             RD_EN,
  output logic      [11:0] RD_ADDR
);
  initial begin
    RD_EN   = 1'b0;
    RD_ADDR = 12'h000;
  end

  // ****************************************************************
  // Read cycle
  // ****************************************************************
  // The address is inverted once released, so a design that samples it
  // late sees garbage instead of a lucky stale value
  task automatic read(input logic [11:0] addr, output logic [15:0] data);
    int n;
    @(negedge CLK);
    RD_EN   = 1'b1;
    RD_ADDR = addr;
    @(negedge CLK);
    RD_EN   = 1'b0;
    RD_ADDR = ~addr;
    data    = 16'hxxxx;
    for (n = 0; n < 4 && RD_VALID !== 1'b1; n++) begin
      @(negedge CLK);
    end
    if (RD_VALID === 1'b1) begin
      data = RD_DATA;
    end
  endtask : read
endmodule : fieldbus_master

// >>> sim/tb.sv
// Self-checking bench for the flame monitor supervisor
`timescale 1ns/10ps
module tb
  import flame_sup_pkg::*;
;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam int BH = 4;
  logic        clk, rst_n, reset_key, sample_valid, record_start;
  logic [7:0]  sample, current_out;
  chan_in_s    ch_one, ch_two;
  logic        rd_en, rd_valid, flame_relay, ready_relay;
  logic        led_error, led_power, led_switch, led_freq;
  logic [11:0] rd_addr;
  logic [15:0] rd_data;
  int          n_errors, total_checks, i, k, n, mn, mx;
  logic [6:0]  code;
  int          causes[4] = '{1, 2, 5, 8};

  flame_monitor_supervisor #(.MISMATCH_LIMIT(20), .HARMONIC_LIMIT(20),
    .BLINK_HALF(BH)) i_flame_monitor_supervisor (
    .CLK(clk), .RST_N(rst_n), .CE(1'b1), .RESET_KEY(reset_key),
    .CH_ONE(ch_one), .CH_TWO(ch_two), .SAMPLE_VALID(sample_valid),
    .SAMPLE(sample), .RECORD_START(record_start), .RD_EN(rd_en),
    .RD_ADDR(rd_addr), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .FLAME_RELAY(flame_relay), .READY_RELAY(ready_relay),
    .LED_ERROR(led_error), .LED_POWER(led_power),
    .LED_SWITCH(led_switch), .LED_FREQ(led_freq),
    .CURRENT_OUT(current_out));

  fieldbus_master i_fieldbus_master (.CLK(clk), .RD_VALID(rd_valid),
    .RD_DATA(rd_data), .RD_EN(rd_en), .RD_ADDR(rd_addr));

  always #5 clk = ~clk;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic rd_chk(logic [11:0] addr, logic [15:0] exp);
    logic [15:0] d;
    i_fieldbus_master.read(addr, d);
    check($sformatf("word %h", addr), d, exp);
  endtask : rd_chk

  task automatic cycles(int c);
    repeat (c) @(negedge clk);
  endtask : cycles

  function automatic logic [7:0] samp(int j);
    return 8'(j * 5 + 9);
  endfunction : samp

  task automatic load_record(bit alt);
    int j;
    record_start = 1'b1;
    cycles(1);
    record_start = 1'b0;
    for (j = 0; j < 128; j++) begin
      sample_valid = 1'b1;
      sample = alt ? (j[0] ? 8'h70 : 8'h10) : samp(j);
      cycles(1);
    end
    sample_valid = 1'b0;
    cycles(2);
  endtask : load_record

  // Finds the long dark gap, then counts flashes up to the next one
  task automatic blink_count(output int cnt);
    int low, guard;
    bit prev;
    low = 0; cnt = 0; guard = 0; prev = 1'b0;
    while (low < 3 * BH && guard < 600) begin
      cycles(1); guard++;
      low = (led_power === 1'b0) ? low + 1 : 0;
    end
    low = 0;
    while ((cnt == 0 || low < 3 * BH) && guard < 600) begin
      cycles(1); guard++;
      if (led_power === 1'b1 && !prev) cnt++;
      prev = (led_power === 1'b1);
      low = prev ? 0 : low + 1;
    end
  endtask : blink_count

  task automatic press_key();
    reset_key = 1'b1;
    cycles(3);
    check("leds", {led_error, led_power, led_switch, led_freq}, 0);
    check("relays", {flame_relay, ready_relay}, 0);
    reset_key = 1'b0;
    cycles(5);
    check("ready", ready_relay, 1);
  endtask : press_key

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  initial begin
    #(30000 * 10);
    n_errors++;
    test_done();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    clk = 0; rst_n = 0; reset_key = 0; sample_valid = 0;
    record_start = 0; sample = 8'h00; n_errors = 0; total_checks = 0;
    ch_one = '0; ch_two = '0;
    ch_one.span_4_20 = 1; ch_one.flame = 1; ch_one.flicker_on = 1;
    ch_two.flame = 1; ch_two.range_b = 1; ch_two.setting_mismatch = 1;
    ch_one.freq_value = 8'h33; ch_two.freq_value = 8'h33;
    cycles(2);
    check("reset outs", {flame_relay, ready_relay, led_error, led_power,
      led_switch, led_freq, current_out}, 0);
    rst_n = 1;
    rd_chk(ADDR_STATUS, 16'ha32d);
    check("switch led", led_switch, 1);
    ch_two.setting_mismatch = 0;
    cycles(40);
    check("freq led steady", led_freq, 1);
    rd_chk(ADDR_STATUS, 16'ha329);
    check("flame kept", flame_relay, 1);
    load_record(1'b0);
    mn = 255; mx = 0;
    for (k = 0; k < 128; k++) begin
      mn = (samp(k) < mn) ? samp(k) : mn;
      mx = (samp(k) > mx) ? samp(k) : mx;
    end
    for (k = 0; k < 64; k++) begin
      rd_chk(ADDR_SAMPLES + 12'(k), {samp(2 * k), samp(2 * k + 1)});
    end
    cycles(1);
    check("valid pulse", rd_valid, 0);
    rd_chk(ADDR_SAMP_LAST + 12'h001, 16'h0000);
    rd_chk(ADDR_MINMAX, {8'(mn), 8'(mx)});
    load_record(1'b1);
    rd_chk(ADDR_MINMAX, 16'h1070);
    rd_chk(ADDR_RMS, 16'h5000);
    for (i = 0; i < 4; i++) begin
      code = 7'(8'h11 + i * 8'h1d);
      if (i % 2 == 0) begin
        ch_one.fault = 1; ch_one.fault_cause = 8'(causes[i]);
        ch_one.error_code = code;
      end else begin
        ch_two.fault = 1; ch_two.fault_cause = 8'(causes[i]);
        ch_two.error_code = code;
      end
      cycles(4);
      check("relays", {flame_relay, ready_relay}, 0);
      check("error led", led_error, 1);
      rd_chk(ADDR_TAG_ERROR, {8'h00, i % 2 == 0, code});
      blink_count(n);
      check("flashes", 16'(n), 16'(causes[i]));
      ch_one.fault = 0; ch_two.fault = 0; ch_one.flame = 0;
      cycles(3);
      ch_one.flame = 1;
      cycles(5);
      check("held", {led_error, flame_relay, ready_relay}, 3'b100);
      press_key();
    end
    ch_one.setting_mismatch = 1;
    cycles(3);
    check("switch led", led_switch, 1);
    cycles(10);
    check("not yet", ready_relay, 1);
    cycles(20);
    check("shutdown", {led_error, ready_relay}, 2'b10);
    blink_count(n);
    check("flashes", 16'(n), 16'(CAUSE_SWITCH));
    ch_one.setting_mismatch = 0;
    press_key();
    ch_one.freq_threshold = 8'h05;
    cycles(30);
    check("flame off", flame_relay, 0);
    check("current", current_out, CURRENT_72MA);
    rd_chk(ADDR_STATUS, 16'h9319);
    n = 0; k = 0;
    repeat (4 * BH) begin
      cycles(1);
      n += (led_freq === 1'b1);
      k += (led_freq === 1'b0);
    end
    check("freq blink", {n > 0, k > 0}, 2'b11);
    test_done();
  end
endmodule : tb
